/* pkg/throttle_pkg.sv */
/*
  Shared constants and types of the memory hub throttling weights block:
  register offsets inside the hub register window, field positions,
  reset values, filter sizing and the command and rank-state carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package throttle_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register window
  localparam int unsigned ADDR_W = 16;
  localparam logic [ADDR_W-1:0] OFS_HUB_EVENT_WEIGHTS   = 16'h1270;
  localparam logic [ADDR_W-1:0] OFS_HUB_THROTTLE_CTRL   = 16'h1274;
  localparam logic [ADDR_W-1:0] OFS_RANK_PASSIVE_WEIGHT = 16'h1278;
  localparam logic [ADDR_W-1:0] OFS_RANK_ACTIVE_WEIGHT  = 16'h1280;

  localparam logic [31:0] RST_HUB_EVENT_WEIGHTS   = 32'h0000_0000;
  localparam logic [31:0] RST_HUB_THROTTLE_CTRL   = 32'h0000_0000;
  localparam logic [63:0] RST_RANK_PASSIVE_WEIGHT = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RST_RANK_ACTIVE_WEIGHT  = 64'h0000_0000_0000_0000;

  // writable bits; everything else reads as zero
  localparam logic [31:0] WMASK_HUB_EVENT_WEIGHTS   = 32'hFFFF_FFFF;
  localparam logic [31:0] WMASK_HUB_THROTTLE_CTRL   = 32'h0030_FFFF;
  localparam logic [63:0] WMASK_RANK_PASSIVE_WEIGHT = 64'h0000_FFFF_FFFF_FFFF;
  localparam logic [63:0] WMASK_RANK_ACTIVE_WEIGHT  = 64'h0000_FFFF_FFFF_FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, every weight is 8 bits wide
  localparam int unsigned WEIGHT_W = 8;

  localparam int unsigned HUB_READ_LSB  = 24;
  localparam int unsigned HUB_WRITE_LSB = 16;
  localparam int unsigned HUB_CMD_LSB   = 8;
  localparam int unsigned HUB_IDLE_LSB  = 0;

  localparam int unsigned CTRL_BW_ENABLE_BIT   = 21;
  localparam int unsigned CTRL_TRIP_ENABLE_BIT = 20;
  localparam int unsigned CTRL_BW_THRESH_LSB   = 8;
  localparam int unsigned CTRL_TH_THRESH_LSB   = 0;

  localparam int unsigned PAS_ODT_LSB          = 40;
  localparam int unsigned PAS_OPEN_ACTIVE_LSB  = 32;
  localparam int unsigned PAS_PRE_ACTIVE_LSB   = 24;
  localparam int unsigned PAS_OPEN_PDOWN_LSB   = 16;
  localparam int unsigned PAS_PRE_PDOWN_LSB    = 8;
  localparam int unsigned PAS_SELF_REFRESH_LSB = 0;

  localparam int unsigned ACT_READ_AP_LSB  = 56;
  localparam int unsigned ACT_WRITE_AP_LSB = 48;
  localparam int unsigned ACT_READ_LSB     = 40;
  localparam int unsigned ACT_WRITE_LSB    = 32;
  localparam int unsigned ACT_PRE_ALL_LSB  = 24;
  localparam int unsigned ACT_PRE_LSB      = 16;
  localparam int unsigned ACT_ACTIVATE_LSB = 8;
  localparam int unsigned ACT_REFRESH_LSB  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // ranks and averaging filters
  localparam int unsigned RANKS = 4;
  // rank input: passive + command + termination, three 8-bit terms
  localparam int unsigned SUM_W = WEIGHT_W + 2;
  // average window is 2**FILTER_SHIFT clocks (exponential form)
  localparam int unsigned FILTER_SHIFT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef enum logic [3:0] {
    CMD_OTHER     = 4'h0,
    CMD_READ      = 4'h1,
    CMD_WRITE     = 4'h2,
    CMD_READ_AP   = 4'h3,
    CMD_WRITE_AP  = 4'h4,
    CMD_PRE_ALL   = 4'h5,
    CMD_PRECHARGE = 4'h6,
    CMD_ACTIVATE  = 4'h7,
    CMD_REFRESH   = 4'h8
  } cmd_kind_type;

  typedef struct packed {
    logic             valid;
    logic [RANKS-1:0] chip_select_n;
    cmd_kind_type     kind;
  } dram_cmd_type;

  typedef struct packed {
    logic odt;
    logic open_page;
    logic powerdown;
    logic self_refresh;
  } rank_state_type;

  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [63:0]       wdata;
  } reg_req_type;

endpackage

/* hw/average_filter.sv */
/*
  One running-average filter of weighted activity.
  Assumes one input sample per clock; output is the average in input units.
*/
`timescale 1ns/100ps
`default_nettype none
module average_filter (
  // clock and reset
  input  wire logic                            i_clk,
  input  wire logic                            i_reset_n,
  // sample in, average out
  input  wire logic [throttle_pkg::SUM_W-1:0]  i_sample,
  output logic      [throttle_pkg::SUM_W-1:0]  o_average
);

  import throttle_pkg::*;

  localparam int unsigned ACC_W = SUM_W + FILTER_SHIFT;

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;

  // acc holds average scaled by the window; no divider, never overflows
  always_comb begin
    next_acc = acc - (acc >> FILTER_SHIFT) + ACC_W'(i_sample);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  assign o_average = acc[ACC_W-1:FILTER_SHIFT];

endmodule
`default_nettype wire

/* hw/rank_weight.sv */
/*
  Per-rank weight selection: passive state weight, plus the command weight
  when chip select is asserted, plus the termination weight when termination is asserted.
  Assumes one-hot rank power states as reported by the command scheduler.
*/
`timescale 1ns/100ps
`default_nettype none
module rank_weight (
  // weight registers
  input  wire logic [63:0]                     i_passive,
  input  wire logic [63:0]                     i_active,
  // rank condition this clock
  input  wire throttle_pkg::rank_state_type    i_state,
  input  wire logic                            i_selected,
  input  wire throttle_pkg::cmd_kind_type      i_kind,
  // filter input
  output logic      [throttle_pkg::SUM_W-1:0]  o_sum
);

  import throttle_pkg::*;

  logic [WEIGHT_W-1:0] passive_w;
  logic [WEIGHT_W-1:0] command_w;
  logic [WEIGHT_W-1:0] odt_w;

  always_comb begin
    if (i_state.self_refresh) begin
      passive_w = i_passive[PAS_SELF_REFRESH_LSB +: WEIGHT_W];
    end else if (i_state.powerdown) begin
      if (i_state.open_page) begin
        passive_w = i_passive[PAS_OPEN_PDOWN_LSB +: WEIGHT_W];
      end else begin
        passive_w = i_passive[PAS_PRE_PDOWN_LSB +: WEIGHT_W];
      end
    end else if (i_state.open_page) begin
      passive_w = i_passive[PAS_OPEN_ACTIVE_LSB +: WEIGHT_W];
    end else begin
      passive_w = i_passive[PAS_PRE_ACTIVE_LSB +: WEIGHT_W];
    end
  end

  // commands with no weight of their own (mode register etc.) add nothing
  always_comb begin
    command_w = '0;
    if (i_selected) begin
      unique case (i_kind)
        CMD_READ:      command_w = i_active[ACT_READ_LSB +: WEIGHT_W];
        CMD_WRITE:     command_w = i_active[ACT_WRITE_LSB +: WEIGHT_W];
        CMD_READ_AP:   command_w = i_active[ACT_READ_AP_LSB +: WEIGHT_W];
        CMD_WRITE_AP:  command_w = i_active[ACT_WRITE_AP_LSB +: WEIGHT_W];
        CMD_PRE_ALL:   command_w = i_active[ACT_PRE_ALL_LSB +: WEIGHT_W];
        CMD_PRECHARGE: command_w = i_active[ACT_PRE_LSB +: WEIGHT_W];
        CMD_ACTIVATE:  command_w = i_active[ACT_ACTIVATE_LSB +: WEIGHT_W];
        CMD_REFRESH:   command_w = i_active[ACT_REFRESH_LSB +: WEIGHT_W];
        default:       command_w = '0;
      endcase
    end
  end

  assign odt_w = i_state.odt ? i_passive[PAS_ODT_LSB +: WEIGHT_W] : '0;

  assign o_sum = SUM_W'(passive_w) + SUM_W'(command_w) + SUM_W'(odt_w);

endmodule
`default_nettype wire

/* hw/dram_power_throttle_weights.sv */
/*
  Memory hub throttling weights: weight and threshold registers, one
  hub-level averaging filter, four per-rank filters and the throttle
  decision that holds off new DDR bus transactions.
  Assumes the register access port, command bus view, rank states, thermal
  trip and throttle lock are all synchronous to i_clk.
*/
// Notes on behaviour
// - bandwidth enable bit 21 arms bandwidth threshold
// - thermal trip with both enabled: thermal threshold
// - trip enable: throttle on trip and average>=threshold
// - trip enable clear: trip starts no throttling
// - bandwidth threshold 15:8, average>=it holds bus
// - thermal threshold 7:0, average>=it holds bus
// - four independent rank filters, own weights only
// - termination asserted adds weight 47:40
// - open page, not powered down: weight 39:32
// - all precharged, not powered down: weight 31:24
// - powered down, pages open: weight 23:16
// - all precharged, powered down: weight 15:8
// - self refresh: weight 7:0
// - chip select adds command weight to passive
// - command weight fields; auto-precharge fields read-only
// - throttle lock blocks weight register writes
// - hub filter: read, write, command, idle weight
// - idle tristated gives zero, reduced drive half
`timescale 1ns/100ps
`default_nettype none
module dram_power_throttle_weights (
  // clock and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_reset_n,
  // register access inside the hub register window
  input  wire throttle_pkg::reg_req_type          i_reg,
  output logic      [63:0]                        o_reg_rdata,
  output logic                                    o_reg_rvalid,
  // lock bit held in the dram throttle control register
  input  wire logic                               i_throttle_lock,
  // command bus as issued this clock
  input  wire throttle_pkg::dram_cmd_type         i_cmd,
  input  wire logic                               i_ca_tristate,
  input  wire logic                               i_ca_reduced_drive,
  // rank conditions this clock
  input  wire throttle_pkg::rank_state_type [3:0] i_rank_state,
  // thermal sensor
  input  wire logic                               i_thermal_trip,
  // throttle result and filter outputs
  output logic                                    o_hold_transactions,
  output logic      [throttle_pkg::SUM_W-1:0]     o_hub_average,
  output logic      [4*throttle_pkg::SUM_W-1:0]   o_rank_average
);

  import throttle_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] hub_event_weights;
  logic [31:0] hub_throttle_control;
  logic [63:0] rank_passive_event_weights;
  logic [63:0] rank_active_event_weights;

  logic write_ok;

  // a locked write is dropped silently; reads still work
  assign write_ok = i_reg.write && !i_throttle_lock;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hub_event_weights <= RST_HUB_EVENT_WEIGHTS;
    end else if (write_ok && i_reg.addr == OFS_HUB_EVENT_WEIGHTS) begin
      hub_event_weights <= i_reg.wdata[31:0] & WMASK_HUB_EVENT_WEIGHTS;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hub_throttle_control <= RST_HUB_THROTTLE_CTRL;
    end else if (write_ok && i_reg.addr == OFS_HUB_THROTTLE_CTRL) begin
      hub_throttle_control <= i_reg.wdata[31:0] & WMASK_HUB_THROTTLE_CTRL;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rank_passive_event_weights <= RST_RANK_PASSIVE_WEIGHT;
    end else if (write_ok && i_reg.addr == OFS_RANK_PASSIVE_WEIGHT) begin
      rank_passive_event_weights <= i_reg.wdata & WMASK_RANK_PASSIVE_WEIGHT;
    end
  end

  // auto-precharge weights sit outside the write mask and stay zero
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rank_active_event_weights <= RST_RANK_ACTIVE_WEIGHT;
    end else if (write_ok && i_reg.addr == OFS_RANK_ACTIVE_WEIGHT) begin
      rank_active_event_weights <= i_reg.wdata & WMASK_RANK_ACTIVE_WEIGHT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read, one clock after the request

  logic [63:0] next_rdata;

  always_comb begin
    unique case (i_reg.addr)
      OFS_HUB_EVENT_WEIGHTS:   next_rdata = {32'h0000_0000, hub_event_weights};
      OFS_HUB_THROTTLE_CTRL:   next_rdata = {32'h0000_0000, hub_throttle_control};
      OFS_RANK_PASSIVE_WEIGHT: next_rdata = rank_passive_event_weights;
      OFS_RANK_ACTIVE_WEIGHT:  next_rdata = rank_active_event_weights;
      default:                 next_rdata = 64'h0000_0000_0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= '0;
    end else if (i_reg.read) begin
      o_reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg.read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hub-level filter input

  logic [WEIGHT_W-1:0] idle_w;
  logic [WEIGHT_W-1:0] hub_w;

  always_comb begin
    if (i_ca_tristate) begin
      idle_w = '0;
    end else if (i_ca_reduced_drive) begin
      idle_w = hub_event_weights[HUB_IDLE_LSB +: WEIGHT_W] >> 1;
    end else begin
      idle_w = hub_event_weights[HUB_IDLE_LSB +: WEIGHT_W];
    end
  end

  always_comb begin
    if (!i_cmd.valid) begin
      hub_w = idle_w;
    end else begin
      unique case (i_cmd.kind)
        CMD_READ, CMD_READ_AP:   hub_w = hub_event_weights[HUB_READ_LSB +: WEIGHT_W];
        CMD_WRITE, CMD_WRITE_AP: hub_w = hub_event_weights[HUB_WRITE_LSB +: WEIGHT_W];
        default:                 hub_w = hub_event_weights[HUB_CMD_LSB +: WEIGHT_W];
      endcase
    end
  end

  average_filter hub_filter (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_sample  (SUM_W'(hub_w)),
    .o_average (o_hub_average)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-rank filters, each fed only from its own rank's condition

  genvar r;
  generate
    for (r = 0; r < RANKS; r++) begin : g_rank
      logic [SUM_W-1:0] rank_sum;

      rank_weight weight_sel (
        .i_passive  (rank_passive_event_weights),
        .i_active   (rank_active_event_weights),
        .i_state    (i_rank_state[r]),
        .i_selected (i_cmd.valid && !i_cmd.chip_select_n[r]),
        .i_kind     (i_cmd.kind),
        .o_sum      (rank_sum)
      );

      average_filter filter (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_sample  (rank_sum),
        .o_average (o_rank_average[r*SUM_W +: SUM_W])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // throttle decision

  logic             bw_enable;
  logic             trip_enable;
  logic             use_thermal;
  logic [SUM_W-1:0] bw_threshold;
  logic [SUM_W-1:0] th_threshold;
  logic             next_hold;

  assign bw_enable    = hub_throttle_control[CTRL_BW_ENABLE_BIT];
  assign trip_enable  = hub_throttle_control[CTRL_TRIP_ENABLE_BIT];
  assign bw_threshold = SUM_W'(hub_throttle_control[CTRL_BW_THRESH_LSB +: WEIGHT_W]);
  assign th_threshold = SUM_W'(hub_throttle_control[CTRL_TH_THRESH_LSB +: WEIGHT_W]);

  // a trip only matters when its enable is set
  assign use_thermal = trip_enable && i_thermal_trip;

  always_comb begin
    if (use_thermal) begin
      next_hold = o_hub_average >= th_threshold;
    end else if (bw_enable) begin
      next_hold = o_hub_average >= bw_threshold;
    end else begin
      next_hold = 1'b0;
    end
  end

  // registered so the scheduler sees a clean level; costs one clock of lag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hold_transactions <= 1'b0;
    end else begin
      o_hold_transactions <= next_hold;
    end
  end

endmodule
`default_nettype wire

/* verif/throttle_sva.sv */
/*
  Checker for the throttling weights block: register answers, control
  readback under the lock, and the registered hold decision.
  Assumes it is bound onto the top module and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module throttle_sva (
  // clock and reset
  input wire logic                           i_clk,
  input wire logic                           i_reset_n,
  // register access
  input wire throttle_pkg::reg_req_type      i_reg,
  input wire logic [63:0]                    o_reg_rdata,
  input wire logic                           o_reg_rvalid,
  input wire logic                           i_throttle_lock,
  // throttle decision
  input wire logic                           i_thermal_trip,
  input wire logic                           o_hold_transactions,
  input wire logic [throttle_pkg::SUM_W-1:0] o_hub_average
);
  import throttle_pkg::*;
  logic [31:0] ctl;
  logic        trip_on;
  logic        bw_on;
  logic        bw_hit;
  logic        th_hit;
  logic        mapped;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the control register; a locked write must leave it alone
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      ctl <= RST_HUB_THROTTLE_CTRL;
    else if (i_reg.write && !i_throttle_lock && i_reg.addr == OFS_HUB_THROTTLE_CTRL)
      ctl <= i_reg.wdata[31:0] & WMASK_HUB_THROTTLE_CTRL;
  end
  assign trip_on = ctl[CTRL_TRIP_ENABLE_BIT] && i_thermal_trip;
  assign bw_on   = ctl[CTRL_BW_ENABLE_BIT] && !trip_on;
  assign bw_hit  = o_hub_average >= {2'h0, ctl[15:8]};
  assign th_hit  = o_hub_average >= {2'h0, ctl[7:0]};
  assign mapped  = i_reg.addr inside {OFS_HUB_EVENT_WEIGHTS, OFS_HUB_THROTTLE_CTRL,
                                      OFS_RANK_PASSIVE_WEIGHT, OFS_RANK_ACTIVE_WEIGHT};
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (i_reg.read |=> o_reg_rvalid)
    else $error("read strobe got no rvalid");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg.read))
    else $error("rvalid without a read");
  a_rdata_holds: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
    else $error("read data moved without rvalid");
  a_unmapped_zero: assert property ((i_reg.read && !mapped) |=> o_reg_rdata == 64'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (
    (i_reg.read && i_reg.addr == OFS_HUB_THROTTLE_CTRL) |=> o_reg_rdata == {32'h0, $past(ctl)})
    else $error("control readback wrong");
  a_bw_hold: assert property (bw_on |=> o_hold_transactions == $past(bw_hit))
    else $error("bandwidth hold wrong");
  a_thermal_hold: assert property (trip_on |=> o_hold_transactions == $past(th_hit))
    else $error("thermal hold wrong");
  a_no_hold: assert property ((!bw_on && !trip_on) |=> !o_hold_transactions)
    else $error("hold with no mode active");
endmodule
bind dram_power_throttle_weights throttle_sva u_sva (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_throttle_lock(i_throttle_lock),
  .i_thermal_trip(i_thermal_trip), .o_hold_transactions(o_hold_transactions),
  .o_hub_average(o_hub_average));
`default_nettype wire

/* verif/dram_rank_model.sv */
/*
  Behavioural ranks on the channel: page state follows the commands that
  select each rank; power and termination states come from the bench.
  Assumes commands are sampled on the rising edge of i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dram_rank_model (
  // clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  // command bus and requested power states
  input  wire throttle_pkg::dram_cmd_type          i_cmd,
  input  wire logic [3:0]                          i_powerdown,
  input  wire logic [3:0]                          i_self_refresh,
  input  wire logic [3:0]                          i_odt,
  // reported rank conditions
  output var  throttle_pkg::rank_state_type [3:0]  o_rank_state
);
  import throttle_pkg::*;
  logic [3:0] open_page;
  // one bank per rank: a precharge or precharge-all closes the rank (auto-precharge does not), a limitation of the model
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      open_page <= 4'h0;
    else if (i_cmd.valid)
      for (int r = 0; r < 4; r++)
        if (!i_cmd.chip_select_n[r] && i_cmd.kind == CMD_ACTIVATE)
          open_page[r] <= 1'b1;
        else if (!i_cmd.chip_select_n[r] && i_cmd.kind inside {CMD_PRE_ALL, CMD_PRECHARGE})
          open_page[r] <= 1'b0;
  end
  always_comb begin
    for (int r = 0; r < 4; r++)
      o_rank_state[r] = '{odt: i_odt[r], open_page: open_page[r],
                          powerdown: i_powerdown[r], self_refresh: i_self_refresh[r]};
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
/*
  Self-checking bench: registers, per-rank and hub weights at steady
  state, and the hold decision for each throttle mode.
  Assumes the filter settles to its input within 300 constant clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import throttle_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 lock = 1'b0;
  logic                 trip = 1'b0;
  logic                 tri_s = 1'b0;
  logic                 red = 1'b0;
  reg_req_type          rq = '0;
  dram_cmd_type         cmd = '0;
  logic [3:0]           pd = 4'h0;
  logic [3:0]           sr = 4'h0;
  logic [3:0]           odt = 4'h0;
  rank_state_type [3:0] rs;
  logic [63:0]          rdata;
  logic                 rvalid;
  logic                 hold;
  logic [9:0]           hub;
  logic [39:0]          ravg;
  int                   errors = 0;
  int                   comparisons = 0;
  logic [15:0] offs [4] = '{OFS_HUB_EVENT_WEIGHTS, OFS_HUB_THROTTLE_CTRL,
                            OFS_RANK_PASSIVE_WEIGHT, OFS_RANK_ACTIVE_WEIGHT};
  logic [63:0] masks [4] = '{{32'h0, WMASK_HUB_EVENT_WEIGHTS}, {32'h0, WMASK_HUB_THROTTLE_CTRL},
                             WMASK_RANK_PASSIVE_WEIGHT, WMASK_RANK_ACTIVE_WEIGHT};
  // control value, trip level, expected hold
  logic [33:0] modes [7] = '{{32'h0020_4000, 2'b01}, {32'h0020_4100, 2'b00},
                             {32'h0000_0000, 2'b00}, {32'h0030_FF40, 2'b11},
                             {32'h0030_FF40, 2'b00}, {32'h0010_0041, 2'b10},
                             {32'h0000_0000, 2'b10}};
  always #12.5 clk = ~clk;
  dram_power_throttle_weights uut (
    .i_clk(clk), .i_reset_n(rst_n), .i_reg(rq), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_throttle_lock(lock), .i_cmd(cmd), .i_ca_tristate(tri_s),
    .i_ca_reduced_drive(red), .i_rank_state(rs), .i_thermal_trip(trip),
    .o_hold_transactions(hold), .o_hub_average(hub), .o_rank_average(ravg));
  dram_rank_model ranks (
    .i_clk(clk), .i_reset_n(rst_n), .i_cmd(cmd), .i_powerdown(pd),
    .i_self_refresh(sr), .i_odt(odt), .o_rank_state(rs));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    rq = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    step(1);
    rq = '0;
    step(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [63:0] want);
    rq = '{write: 1'b0, read: 1'b1, addr: a, wdata: 64'h0};
    step(1);
    rq = '0;
    check(rvalid, 1'b1);
    check(rdata, want);
    step(1);
  endtask
  function automatic logic [9:0] cmd_w(input cmd_kind_type k);
    case (k)
      CMD_READ:      return 10'h090;
      CMD_WRITE:     return 10'h080;
      CMD_PRE_ALL:   return 10'h070;
      CMD_PRECHARGE: return 10'h060;
      CMD_ACTIVATE:  return 10'h058;
      CMD_REFRESH:   return 10'h048;
      default:       return 10'h000;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_registers();
    foreach (offs[i]) rd(offs[i], 64'h0);
    foreach (offs[i]) wr(offs[i], {64{1'b1}});
    foreach (offs[i]) rd(offs[i], masks[i]);
    lock = 1'b1;
    wr(OFS_RANK_PASSIVE_WEIGHT, 64'h0);
    rd(OFS_RANK_PASSIVE_WEIGHT, WMASK_RANK_PASSIVE_WEIGHT);
    lock = 1'b0;
    wr(16'h1290, 64'h1);
    rd(16'h1290, 64'h0);
    wr(OFS_HUB_EVENT_WEIGHTS, 64'hC0A0_6051);
    wr(OFS_RANK_PASSIVE_WEIGHT, 64'h0000_5040_3020_1008);
    wr(OFS_RANK_ACTIVE_WEIGHT, 64'hFFFF_9080_7060_5848);
    rd(OFS_RANK_ACTIVE_WEIGHT, 64'h0000_9080_7060_5848);
  endtask
  // pages open on ranks of om, then a constant condition until filters settle
  task automatic run_case(input logic [3:0] om, input logic [3:0] pm, input logic [3:0] sm,
                          input logic [3:0] dm, input logic v, input cmd_kind_type k,
                          input logic [3:0] sel);
    logic [9:0] w;
    logic       o;
    logic       hit;
    cmd = '{valid: 1'b1, chip_select_n: 4'h0, kind: CMD_PRE_ALL};
    step(1);
    cmd = '{valid: 1'b1, chip_select_n: ~om, kind: CMD_ACTIVATE};
    step(1);
    pd = pm;
    sr = sm;
    odt = dm;
    cmd = '{valid: v, chip_select_n: ~sel, kind: k};
    step(300);
    for (int r = 0; r < 4; r++) begin
      hit = v && sel[r];
      o = (hit && k == CMD_ACTIVATE) || (om[r] && !(hit && k inside {CMD_PRE_ALL, CMD_PRECHARGE}));
      w = sm[r] ? 10'h008 : pm[r] ? (o ? 10'h020 : 10'h010) : (o ? 10'h040 : 10'h030);
      w = w + (hit ? cmd_w(k) : 10'h000) + (dm[r] ? 10'h050 : 10'h000);
      check(ravg[r*10 +: 10], w);
    end
    if (!v)
      w = tri_s ? 10'h000 : red ? 10'h028 : 10'h051;
    else if (k inside {CMD_READ, CMD_READ_AP})
      w = 10'h0C0;
    else if (k inside {CMD_WRITE, CMD_WRITE_AP})
      w = 10'h0A0;
    else
      w = 10'h060;
    check(hub, w);
  endtask
  task automatic t_rank_and_hub();
    run_case(4'b0101, 4'b0011, 4'h0, 4'h0, 1'b0, CMD_OTHER, 4'h0);
    run_case(4'h0, 4'h0, 4'b1000, 4'b0110, 1'b1, CMD_READ, 4'b0001);
    for (int k = 0; k < 9; k++)
      run_case(4'b0010, 4'h0, 4'h0, 4'b0001, 1'b1, cmd_kind_type'(k), 4'b0010);
    for (int i = 1; i < 4; i++) begin
      tri_s = i[0];
      red = i[1];
      run_case(4'h0, 4'h0, 4'h0, 4'h0, 1'b0, CMD_OTHER, 4'h0);
    end
  endtask
  // idle average settles at 0x40, the boundary of the 0x40 and 0x41 thresholds used
  task automatic t_throttle();
    tri_s = 1'b0;
    red = 1'b0;
    cmd = '0;
    wr(OFS_HUB_EVENT_WEIGHTS, 64'h40);
    step(300);
    foreach (modes[i]) begin
      wr(OFS_HUB_THROTTLE_CTRL, {32'h0, modes[i][33:2]});
      trip = modes[i][1];
      step(3);
      check(hold, modes[i][0]);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    step(12);
    rst_n = 1'b1;
    t_registers();
    t_rank_and_hub();
    t_throttle();
    give_verdict();
  end
endmodule
`default_nettype wire
